//--- hw/board_regs_pkg.sv
// constants and carrier types for the board control and status register group
// How it works
// - trigger-output mask bits 7:0 let each channel's threshold crossing drive trigger out
// - mask bit 30 passes external trigger, bit 31 software trigger, to trigger out
// - post-trigger samples are four times the setting plus a fixed latency
// - io data read returns the sixteen line levels; writes set output levels
// - with io control bit 15 clear, trigger out follows the mask-based generation
// - with io control bit 15 set, trigger out is the static level of bit 14
// - io control bits 7:6 pick gpio, programmed or pattern mode; pattern captures inputs
// - io control bits 5:2 set direction of line groups 15-12, 11-8, 7-4, 3-0
// - group direction bits act only in gpio mode, ignored otherwise
// - io control bit 1 puts trigger-out and clock-out pins in high impedance
// - io control bit 0 picks nim or ttl levels, passed to the pad control
// - only channels enabled in the eight-bit mask contribute samples to events
// - firmware revision reads date in 31:16, major in 15:8, minor in 7:0
// - event count reports stored events, never above the permitted buffer number
// - monitor dac holds a twelve-bit code, forwarded in voltage-level monitor mode
// - monitor mode selects majority, ramp, reserved, occupancy or voltage level
// - event size register returns 32-bit word count of the next event
// - acquisition runs while run bit 2 of acquisition control is set
package board_regs_pkg;

    // register offsets (low address bits)
    localparam logic [15:0] OFS_TRIG_OUT_MASK = 16'h8110;
    localparam logic [15:0] OFS_POST_TRIG = 16'h8114;
    localparam logic [15:0] OFS_IO_LEVELS = 16'h8118;
    localparam logic [15:0] OFS_IO_CONFIG = 16'h811C;
    localparam logic [15:0] OFS_CHAN_MASK = 16'h8120;
    localparam logic [15:0] OFS_FW_VERSION = 16'h8124;
    localparam logic [15:0] OFS_EVENT_COUNT = 16'h812C;
    localparam logic [15:0] OFS_MON_DAC = 16'h8138;
    localparam logic [15:0] OFS_BOARD_DESC = 16'h8140;
    localparam logic [15:0] OFS_MON_SELECT = 16'h8144;
    localparam logic [15:0] OFS_EVENT_SIZE = 16'h814C;

    // writable bit masks; everything else is reserved
    localparam logic [31:0] TRIG_OUT_WR_MASK = 32'hC00000FF;
    localparam logic [15:0] IO_CONFIG_WR_MASK = 16'hC0FF;

    // field positions
    localparam int TOM_EXT_BIT = 30;
    localparam int TOM_SW_BIT = 31;
    localparam int FW_DATE_LSB = 16;
    localparam int FW_MAJOR_LSB = 8;
    localparam int FW_MINOR_LSB = 0;
    localparam int BD_MEM_LSB = 8;
    localparam int BD_TYPE_LSB = 0;
    localparam int POST_TRIG_SHIFT = 2;
    localparam int LINES_PER_GROUP = 4;

    // widths
    localparam int NUM_CHANNELS = 8;
    localparam int NUM_LVDS = 16;
    localparam int DAC_W = 12;
    localparam int MON_W = 3;

    // reset values
    localparam logic [31:0] TRIG_OUT_MASK_RST = 32'h00000000;
    localparam logic [31:0] POST_TRIG_RST = 32'h00000000;
    localparam logic [15:0] IO_LEVELS_RST = 16'h0000;
    localparam logic [15:0] IO_CONFIG_RST = 16'h0000;
    localparam logic [7:0] CHAN_MASK_RST = 8'h00;
    localparam logic [11:0] MON_DAC_RST = 12'h000;
    localparam logic [2:0] MON_SELECT_RST = 3'h0;

    // fixed trigger processing latency in samples, plain default
    localparam int FIXED_TRIGGER_LATENCY_DEF = 16;

    // monitor source codes
    localparam logic [2:0] MON_MAJORITY = 3'h0;
    localparam logic [2:0] MON_RAMP = 3'h1;
    localparam logic [2:0] MON_RESERVED = 3'h2;
    localparam logic [2:0] MON_OCCUPANCY = 3'h3;
    localparam logic [2:0] MON_VOLTAGE = 3'h4;

    typedef enum logic [1:0] {
        LVDS_GPIO = 2'h0,
        LVDS_PROG = 2'h1,
        LVDS_PATTERN = 2'h2
    } lvds_mode_t;

    // io control register layout, bit 15 first
    typedef struct packed {
        logic test_en;
        logic test_lvl;
        logic [5:0] rsvd;
        logic [1:0] lvds_mode;
        logic [3:0] grp_dir;
        logic panel_hiz;
        logic ttl_sel;
    } panel_cfg_t;

    // host access request
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [31:0] wdata;
    } reg_req_t;

endpackage

//--- hw/sync_two_ff.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
module sync_two_ff #(
    parameter int W = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule

//--- hw/trig_out_gen.sv
// front-panel trigger output source selection and test level
`timescale 1ns/10ps
module trig_out_gen #(
    parameter int NCH = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [NCH-1:0] chan_over_thr_i,
    input wire logic ext_trig_i,
    input wire logic sw_trig_i,
    input wire logic [31:0] src_mask_i,
    input wire logic test_en_i,
    input wire logic test_lvl_i,
    output logic trig_o
);
    logic chan_hit;
    logic ext_hit;
    logic sw_hit;
    logic normal_trig;
    logic trig_d;
    logic trig_q;

    assign chan_hit = |(chan_over_thr_i & src_mask_i[NCH-1:0]);
    assign ext_hit = ext_trig_i & src_mask_i[board_regs_pkg::TOM_EXT_BIT];
    assign sw_hit = sw_trig_i & src_mask_i[board_regs_pkg::TOM_SW_BIT];
    assign normal_trig = chan_hit | ext_hit | sw_hit;
    // test mode overrides generation entirely
    assign trig_d = test_en_i ? test_lvl_i : normal_trig;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= trig_d;
        end
    end

    assign trig_o = trig_q;
endmodule

//--- hw/board_control_regs.sv
// board-level control and status registers of the digitizer
`timescale 1ns/10ps
module board_control_regs #(
    parameter int FIXED_TRIGGER_LATENCY = board_regs_pkg::FIXED_TRIGGER_LATENCY_DEF,
    parameter logic [15:0] FW_DATE = 16'h0000,
    parameter logic [7:0] FW_MAJOR = 8'h00,
    parameter logic [7:0] FW_MINOR = 8'h00,
    // arbitrary neutral value
    parameter logic [7:0] BOARD_TYPE = 8'h5A,
    parameter logic [7:0] MEM_SIZE_MB = 8'h01
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic soft_rst_i,
    input wire board_regs_pkg::reg_req_t req_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_ack_o,
    input wire logic run_i,
    input wire logic [7:0] chan_over_thr_i,
    input wire logic ext_trig_i,
    input wire logic sw_trig_i,
    input wire logic [15:0] lvds_in_i,
    output logic [15:0] lvds_out_o,
    output logic [15:0] lvds_oe_o,
    output logic trigger_output_pin_o,
    output logic trigger_output_oe_o,
    output logic clock_output_oe_o,
    output logic panel_ttl_sel_o,
    output logic [15:0] pattern_o,
    output logic [7:0] chan_sample_en_o,
    output logic [33:0] post_trigger_samples_o,
    input wire logic [31:0] event_count_i,
    input wire logic [31:0] buffer_limit_i,
    input wire logic [31:0] event_size_i,
    output logic [2:0] monitor_mode_o,
    output logic [11:0] monitor_dac_o,
    output logic monitor_dac_valid_o
);
    // ---------------- writable state
    logic [31:0] trig_mask_q;
    logic [31:0] post_trig_q;
    logic [15:0] io_levels_q;
    board_regs_pkg::panel_cfg_t io_cfg_q;
    logic [7:0] chan_mask_q;
    logic [11:0] mon_dac_q;
    logic [2:0] mon_sel_q;

    // ---------------- synchronised pins
    logic [15:0] lvds_sync;
    logic ext_sync;
    logic trig_gen;

    sync_two_ff #(
        .W(board_regs_pkg::NUM_LVDS)
    ) u_lvds_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .d_i(lvds_in_i),
        .q_o(lvds_sync)
    );

    sync_two_ff #(
        .W(1)
    ) u_ext_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .d_i(ext_trig_i),
        .q_o(ext_sync)
    );

    trig_out_gen #(
        .NCH(board_regs_pkg::NUM_CHANNELS)
    ) u_trig_out (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .chan_over_thr_i(chan_over_thr_i),
        .ext_trig_i(ext_sync),
        .sw_trig_i(sw_trig_i),
        .src_mask_i(trig_mask_q),
        .test_en_i(io_cfg_q.test_en),
        .test_lvl_i(io_cfg_q.test_lvl),
        .trig_o(trig_gen)
    );

    // ---------------- address decode
    logic any_rst;
    logic hit_tmask;
    logic hit_post;
    logic hit_levels;
    logic hit_cfg;
    logic hit_chan;
    logic hit_fw;
    logic hit_evcnt;
    logic hit_dac;
    logic hit_board;
    logic hit_mon;
    logic hit_evsize;

    assign any_rst = rst_i | soft_rst_i;
    assign hit_tmask = (req_i.addr == board_regs_pkg::OFS_TRIG_OUT_MASK);
    assign hit_post = (req_i.addr == board_regs_pkg::OFS_POST_TRIG);
    assign hit_levels = (req_i.addr == board_regs_pkg::OFS_IO_LEVELS);
    assign hit_cfg = (req_i.addr == board_regs_pkg::OFS_IO_CONFIG);
    assign hit_chan = (req_i.addr == board_regs_pkg::OFS_CHAN_MASK);
    assign hit_fw = (req_i.addr == board_regs_pkg::OFS_FW_VERSION);
    assign hit_evcnt = (req_i.addr == board_regs_pkg::OFS_EVENT_COUNT);
    assign hit_dac = (req_i.addr == board_regs_pkg::OFS_MON_DAC);
    assign hit_board = (req_i.addr == board_regs_pkg::OFS_BOARD_DESC);
    assign hit_mon = (req_i.addr == board_regs_pkg::OFS_MON_SELECT);
    assign hit_evsize = (req_i.addr == board_regs_pkg::OFS_EVENT_SIZE);

    // mask changes during a run would corrupt event framing, so they are dropped
    logic chan_wr_ok;
    assign chan_wr_ok = req_i.wr & hit_chan & ~run_i;

    // ---------------- register writes
    always_ff @(posedge clk_sys_i) begin
        if (any_rst) begin
            trig_mask_q <= board_regs_pkg::TRIG_OUT_MASK_RST;
            post_trig_q <= board_regs_pkg::POST_TRIG_RST;
            io_levels_q <= board_regs_pkg::IO_LEVELS_RST;
            io_cfg_q <= board_regs_pkg::IO_CONFIG_RST;
            chan_mask_q <= board_regs_pkg::CHAN_MASK_RST;
            mon_dac_q <= board_regs_pkg::MON_DAC_RST;
            mon_sel_q <= board_regs_pkg::MON_SELECT_RST;
        end else if (req_i.wr) begin
            if (hit_tmask) begin
                trig_mask_q <= req_i.wdata & board_regs_pkg::TRIG_OUT_WR_MASK;
            end
            if (hit_post) begin
                post_trig_q <= req_i.wdata;
            end
            if (hit_levels) begin
                io_levels_q <= req_i.wdata[15:0];
            end
            if (hit_cfg) begin
                io_cfg_q <= req_i.wdata[15:0] & board_regs_pkg::IO_CONFIG_WR_MASK;
            end
            if (chan_wr_ok) begin
                chan_mask_q <= req_i.wdata[7:0];
            end
            if (hit_dac) begin
                mon_dac_q <= req_i.wdata[11:0];
            end
            if (hit_mon) begin
                mon_sel_q <= req_i.wdata[2:0];
            end
        end
    end

    // ---------------- read-only views, live
    logic [31:0] fw_word;
    logic [31:0] board_word;
    logic [31:0] evcnt_word;

    assign fw_word = {FW_DATE, FW_MAJOR, FW_MINOR};
    assign board_word = {16'h0000, MEM_SIZE_MB, BOARD_TYPE};
    // clamp guards against a transient overshoot in the buffer manager
    assign evcnt_word = (event_count_i > buffer_limit_i) ? buffer_limit_i
                                                         : event_count_i;

    logic [31:0] rd_mux;
    assign rd_mux = hit_tmask ? trig_mask_q :
                    hit_post ? post_trig_q :
                    hit_levels ? {16'h0000, lvds_sync} :
                    hit_cfg ? {16'h0000, io_cfg_q} :
                    hit_chan ? {24'h000000, chan_mask_q} :
                    hit_fw ? fw_word :
                    hit_evcnt ? evcnt_word :
                    hit_dac ? {20'h00000, mon_dac_q} :
                    hit_board ? board_word :
                    hit_mon ? {29'h00000000, mon_sel_q} :
                    hit_evsize ? event_size_i :
                    32'h00000000;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h00000000;
            reg_ack_o <= 1'b0;
        end else begin
            reg_rdata_o <= req_i.rd ? rd_mux : 32'h00000000;
            reg_ack_o <= req_i.rd | req_i.wr;
        end
    end

    // ---------------- lvds direction and levels
    logic is_gpio;
    logic is_prog;
    logic is_pattern;
    logic [15:0] lvds_oe_d;

    assign is_gpio = (io_cfg_q.lvds_mode == board_regs_pkg::LVDS_GPIO);
    assign is_prog = (io_cfg_q.lvds_mode == board_regs_pkg::LVDS_PROG);
    assign is_pattern = (io_cfg_q.lvds_mode == board_regs_pkg::LVDS_PATTERN);

    genvar gi;
    generate
        for (gi = 0; gi < board_regs_pkg::NUM_LVDS; gi++) begin : g_line
            // group direction only counts in gpio mode
            assign lvds_oe_d[gi] = is_gpio ?
                io_cfg_q.grp_dir[gi / board_regs_pkg::LINES_PER_GROUP] :
                is_prog;
        end
    endgenerate

    // pattern latched on any trigger so the header sees a stable value
    logic pattern_take;
    assign pattern_take = is_pattern & (|chan_over_thr_i | ext_sync | sw_trig_i);

    // ---------------- derived outputs
    logic [33:0] post_samples_d;
    assign post_samples_d = ({2'b00, post_trig_q} << board_regs_pkg::POST_TRIG_SHIFT)
                            + 34'(FIXED_TRIGGER_LATENCY);

    logic dac_active;
    assign dac_active = (mon_sel_q == board_regs_pkg::MON_VOLTAGE);

    always_ff @(posedge clk_sys_i) begin
        if (any_rst) begin
            lvds_out_o <= 16'h0000;
            lvds_oe_o <= 16'h0000;
            pattern_o <= 16'h0000;
            trigger_output_pin_o <= 1'b0;
            trigger_output_oe_o <= 1'b0;
            clock_output_oe_o <= 1'b0;
            panel_ttl_sel_o <= 1'b0;
            chan_sample_en_o <= 8'h00;
            post_trigger_samples_o <= 34'h000000000;
            monitor_mode_o <= 3'h0;
            monitor_dac_o <= 12'h000;
            monitor_dac_valid_o <= 1'b0;
        end else begin
            lvds_out_o <= io_levels_q;
            lvds_oe_o <= is_pattern ? 16'h0000 : lvds_oe_d;
            if (pattern_take) begin
                pattern_o <= lvds_sync;
            end
            trigger_output_pin_o <= trig_gen;
            trigger_output_oe_o <= ~io_cfg_q.panel_hiz;
            clock_output_oe_o <= ~io_cfg_q.panel_hiz;
            panel_ttl_sel_o <= io_cfg_q.ttl_sel;
            chan_sample_en_o <= chan_mask_q;
            post_trigger_samples_o <= post_samples_d;
            monitor_mode_o <= mon_sel_q;
            monitor_dac_o <= dac_active ? mon_dac_q : 12'h000;
            monitor_dac_valid_o <= dac_active;
        end
    end
endmodule

//--- tb/board_regs_properties.sv
// concurrent checks on the board register group ports
`timescale 1ns/10ps
module board_regs_properties #(
    parameter int FIXED_TRIGGER_LATENCY = 16,
    parameter logic [15:0] FW_DATE = 16'h0000,
    parameter logic [7:0] FW_MAJOR = 8'h00,
    parameter logic [7:0] FW_MINOR = 8'h00
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic soft_rst_i,
    input wire board_regs_pkg::reg_req_t req_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic reg_ack_o,
    input wire logic run_i,
    input wire logic [15:0] lvds_oe_o,
    input wire logic trigger_output_pin_o,
    input wire logic trigger_output_oe_o,
    input wire logic clock_output_oe_o,
    input wire logic [7:0] chan_sample_en_o,
    input wire logic [33:0] post_trigger_samples_o,
    input wire logic [31:0] event_count_i,
    input wire logic [31:0] buffer_limit_i
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic [31:0] wd1_q;
    logic [31:0] wd2_q;
    wire logic any_w = req_i.wr || req_i.rd;
    wire logic cfg_w = req_i.wr && req_i.addr == board_regs_pkg::OFS_IO_CONFIG && !soft_rst_i;
    wire logic pt_w = req_i.wr && req_i.addr == board_regs_pkg::OFS_POST_TRIG && !soft_rst_i;
    wire logic quiet = !req_i.wr && !soft_rst_i;
    wire logic [1:0] md = wd2_q[7:6];
    wire logic [15:0] grp = {{4{wd2_q[5]}}, {4{wd2_q[4]}}, {4{wd2_q[3]}}, {4{wd2_q[2]}}};
    wire logic [15:0] oe_x = (md == 2'h0) ? grp : {16{md == 2'h1}};
    // write data two cycles back lines up with registered derived outputs
    always_ff @(posedge clk_sys_i) begin
        wd1_q <= req_i.wdata;
        wd2_q <= wd1_q;
    end
    AST_ACK: assert property (reg_ack_o == $past(any_w))
        else $error("ack not one cycle after request");
    AST_FW: assert property (req_i.rd && req_i.addr == board_regs_pkg::OFS_FW_VERSION
        |=> reg_rdata_o == {FW_DATE, FW_MAJOR, FW_MINOR}) else $error("revision word wrong");
    AST_RSV: assert property (req_i.rd && req_i.addr == board_regs_pkg::OFS_TRIG_OUT_MASK
        |=> reg_rdata_o[29:8] == 22'h0) else $error("reserved mask bits not zero");
    AST_EVT: assert property (req_i.rd && req_i.addr == board_regs_pkg::OFS_EVENT_COUNT
        |=> reg_rdata_o <= $past(buffer_limit_i)) else $error("event count above limit");
    AST_POST: assert property (pt_w ##1 !soft_rst_i |-> ##1
        post_trigger_samples_o == {wd2_q, 2'b00} + 34'(FIXED_TRIGGER_LATENCY))
        else $error("post trigger samples wrong");
    AST_TEST: assert property (cfg_w && req_i.wdata[15] ##1 quiet [*4]
        |-> trigger_output_pin_o == $past(req_i.wdata[14], 4)) else $error("test level wrong");
    AST_HIZ: assert property (cfg_w ##1 !soft_rst_i |-> ##1
        (trigger_output_oe_o != wd2_q[1]) && (clock_output_oe_o != wd2_q[1]))
        else $error("panel output enable wrong");
    AST_OE: assert property (cfg_w ##1 !soft_rst_i |-> ##1 lvds_oe_o == oe_x)
        else $error("line direction wrong");
    AST_CHAN: assert property ((run_i && !soft_rst_i) [*3] |-> $stable(chan_sample_en_o))
        else $error("channel mask changed while running");
endmodule
bind board_control_regs board_regs_properties #(
    .FIXED_TRIGGER_LATENCY(FIXED_TRIGGER_LATENCY), .FW_DATE(FW_DATE),
    .FW_MAJOR(FW_MAJOR), .FW_MINOR(FW_MINOR)) u_props (.*);

//--- tb/host_bus_model.sv
// host model issuing single register accesses and owning the run level
`timescale 1ns/10ps
module host_bus_model (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic bad_i,
    input wire logic run_req_i,
    input wire board_regs_pkg::reg_req_t cmd_i,
    input wire logic reg_ack_i,
    input wire logic [31:0] reg_rdata_i,
    output board_regs_pkg::reg_req_t req_o,
    output logic run_o,
    output logic done_o,
    output logic [31:0] rdata_o
);
    logic stop_q;
    logic pend_q;
    board_regs_pkg::reg_req_t cmd_q;
    wire logic mask_w = cmd_i.wr && cmd_i.addr == board_regs_pkg::OFS_CHAN_MASK;
    always_ff @(posedge clk_sys_i) begin
        req_o <= '0;
        done_o <= reg_ack_i && !rst_i;
        if (reg_ack_i) rdata_o <= reg_rdata_i;
        if (rst_i) begin
            stop_q <= 1'h0;
            pend_q <= 1'h0;
            run_o <= 1'h0;
        end else if (go_i && mask_w && run_o && !bad_i) begin
            // stop first, write one cycle later; bad_i breaks this on purpose
            stop_q <= 1'h1;
            pend_q <= 1'h1;
            cmd_q <= cmd_i;
            run_o <= 1'h0;
        end else begin
            run_o <= run_req_i && !stop_q;
            if (!run_req_i) stop_q <= 1'h0;
            pend_q <= 1'h0;
            if (go_i) req_o <= cmd_i;
            if (pend_q) req_o <= cmd_q;
        end
    end
endmodule

//--- tb/testbench.sv
// self-checking bench for the board register group
`timescale 1ns/10ps
module testbench;
    localparam int LAT = 7;
    logic clk_sys_i = 0, rst_i = 1, soft_rst_i = 0, run_i, go = 0, bad = 0, run_req = 0;
    logic reg_ack_o, done, ext_trig_i = 0, sw_trig_i = 0, trigger_output_pin_o;
    logic trigger_output_oe_o, clock_output_oe_o, panel_ttl_sel_o, monitor_dac_valid_o;
    logic [7:0] chan_over_thr_i = 0, chan_sample_en_o;
    logic [15:0] lvds_in_i = 0, lvds_out_o, lvds_oe_o, pattern_o;
    logic [31:0] event_count_i = 0, buffer_limit_i = 0, event_size_i = 0, reg_rdata_o, rdat, d, e;
    logic [33:0] post_trigger_samples_o;
    logic [2:0] monitor_mode_o;
    logic [11:0] monitor_dac_o;
    logic [9:0] s;
    board_regs_pkg::reg_req_t req_i, cmd = '0;
    int failures = 0, tests_run = 0, i, j;
    logic [15:0] ofs [7] = '{board_regs_pkg::OFS_TRIG_OUT_MASK, board_regs_pkg::OFS_POST_TRIG,
        board_regs_pkg::OFS_IO_LEVELS, board_regs_pkg::OFS_IO_CONFIG, board_regs_pkg::OFS_CHAN_MASK,
        board_regs_pkg::OFS_MON_DAC, board_regs_pkg::OFS_MON_SELECT};
    logic [31:0] msk [7] = '{board_regs_pkg::TRIG_OUT_WR_MASK, 32'hFFFFFFFF, 32'h0000FFFF,
        {16'h0, board_regs_pkg::IO_CONFIG_WR_MASK}, 32'h000000FF, 32'h00000FFF, 32'h00000007};

    board_control_regs #(.FIXED_TRIGGER_LATENCY(LAT), .FW_DATE(16'h9316), .FW_MAJOR(8'h03),
        .FW_MINOR(8'h0A), .BOARD_TYPE(8'h3C), .MEM_SIZE_MB(8'h02)) i_board_control_regs (.*);
    host_bus_model i_host_bus_model (.clk_sys_i, .rst_i, .go_i(go), .bad_i(bad),
        .run_req_i(run_req), .cmd_i(cmd), .reg_ack_i(reg_ack_o), .reg_rdata_i(reg_rdata_o),
        .req_o(req_i), .run_o(run_i), .done_o(done), .rdata_o(rdat));

    always #2.5 clk_sys_i = ~clk_sys_i;

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(string n, logic [33:0] x, logic [33:0] g);
        tests_run++;
        if (g !== x) begin
            failures++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic wait_n(int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic acc(logic w, logic [15:0] a, logic [31:0] x);
        int k;
        @(posedge clk_sys_i);
        go <= 1'h1;
        cmd <= '{addr: a, wr: w, rd: !w, wdata: x};
        @(posedge clk_sys_i);
        go <= 1'h0;
        for (k = 0; k < 20 && done !== 1'h1; k++) @(posedge clk_sys_i);
        if (k == 20) begin
            failures++;
            test_done();
        end
    endtask
    function automatic logic [15:0] oe_exp(logic [1:0] m, logic [3:0] g);
        logic [15:0] r;
        for (int k = 0; k < 4; k++) r[k*4 +: 4] = {4{g[k]}};
        return (m == 2'h0) ? r : (m == 2'h1) ? 16'hFFFF : 16'h0000;
    endfunction

    initial begin
        void'($urandom(32'hAB9FE18F));
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'h0;
        for (i = 0; i < 7; i++) begin
            acc(0, ofs[i], 0);
            chk("reset_value", '0, rdat);
        end
        for (j = 0; j < 21; j++) begin
            i = j % 7;
            d = (j >= 7) ? $urandom : (i == 1) ? 32'hBFFFFFFF : 32'hFFFFFFFF;
            // the levels register reads the pins, so the lines carry the same word
            if (i == 2) lvds_in_i <= d[15:0];
            acc(1, ofs[i], d);
            acc(0, ofs[i], 0);
            chk("readback", d & msk[i], rdat);
            if (i == 1) chk("post_samples", {2'h0, d} * 4 + 34'(LAT), post_trigger_samples_o);
            if (i == 2) chk("lvds_out", d[15:0], lvds_out_o);
        end
        $display("register access test done");
        acc(0, board_regs_pkg::OFS_FW_VERSION, 0);
        chk("fw_version", 32'h9316030A, rdat);
        acc(0, board_regs_pkg::OFS_BOARD_DESC, 0);
        chk("board_desc", 32'h0000023C, rdat);
        for (j = 0; j < 6; j++) begin
            event_count_i <= $urandom_range(40);
            buffer_limit_i <= $urandom_range(32);
            event_size_i <= $urandom;
            acc(0, board_regs_pkg::OFS_EVENT_COUNT, 0);
            e = (event_count_i > buffer_limit_i) ? buffer_limit_i : event_count_i;
            chk("event_count", e, rdat);
            acc(0, board_regs_pkg::OFS_EVENT_SIZE, 0);
            chk("event_size", event_size_i, rdat);
        end
        acc(1, 16'h8128, 32'hFFFFFFFF);
        acc(0, 16'h8128, 0);
        chk("unmapped", '0, rdat);
        $display("status test done");
        acc(1, ofs[3], 0);
        for (i = 0; i < 10; i++) begin
            acc(1, ofs[0], (i < 8) ? 32'h1 << i : 32'h1 << (i + 22));
            for (j = 0; j < 2; j++) begin
                s = 10'($urandom);
                s[i] = j[0];
                {sw_trig_i, ext_trig_i, chan_over_thr_i} <= s;
                wait_n(6);
                chk("trigger_out", j, trigger_output_pin_o);
            end
        end
        {sw_trig_i, ext_trig_i, chan_over_thr_i} <= 10'h3FF;
        acc(1, ofs[0], 32'hC00000FF);
        for (j = 0; j < 2; j++) begin
            acc(1, ofs[3], 32'h8000 | (j << 14));
            wait_n(4);
            chk("test_level", j, trigger_output_pin_o);
        end
        {sw_trig_i, ext_trig_i, chan_over_thr_i} <= 10'h0;
        $display("trigger output test done");
        for (j = 0; j < 6; j++) begin
            d = $urandom & 32'h3F;
            // walks all four mode codes, ending in pattern mode for the capture test
            d[7:6] = 2'((j + 1) % 4);
            acc(1, ofs[3], d);
            wait_n(2);
            chk("lvds_oe", oe_exp(d[7:6], d[5:2]), lvds_oe_o);
            chk("panel_oe", {2{~d[1]}}, {trigger_output_oe_o, clock_output_oe_o});
            chk("ttl_sel", d[0], panel_ttl_sel_o);
        end
        d = $urandom;
        lvds_in_i <= d[15:0];
        wait_n(3);
        sw_trig_i <= 1'h1;
        wait_n(1);
        sw_trig_i <= 1'h0;
        wait_n(3);
        chk("pattern", d[15:0], pattern_o);
        acc(0, ofs[2], 0);
        chk("lvds_in", d[15:0], rdat);
        $display("panel io test done");
        acc(1, ofs[4], 32'hA5);
        wait_n(2);
        chk("chan_en", 8'hA5, chan_sample_en_o);
        run_req <= 1'h1;
        bad <= 1'h1;
        wait_n(2);
        acc(1, ofs[4], 32'h3C);
        acc(0, ofs[4], 0);
        chk("mask_in_run", 32'hA5, rdat);
        bad <= 1'h0;
        acc(1, ofs[4], 32'h3C);
        wait_n(2);
        chk("run_stopped", '0, run_i);
        chk("chan_en", 8'h3C, chan_sample_en_o);
        run_req <= 1'h0;
        for (j = 0; j < 5; j++) begin
            d = $urandom;
            acc(1, ofs[5], d);
            acc(1, ofs[6], j);
            wait_n(2);
            chk("mon_mode", j, monitor_mode_o);
            chk("mon_dac", (j == 4) ? {1'h1, d[11:0]} : 13'h0,
                {monitor_dac_valid_o, monitor_dac_o});
        end
        soft_rst_i <= 1'h1;
        wait_n(1);
        soft_rst_i <= 1'h0;
        acc(0, ofs[0], 0);
        chk("soft_reset", '0, rdat);
        chk("soft_reset_en", '0, chan_sample_en_o);
        $display("mask monitor reset test done");
        test_done();
    end
endmodule
